// [dv/lbsc_assertions.sv]
// concurrent checks on the top ports
// assumes a bind onto local_bus_side_control and the single clock CLK
`default_nettype none

module lbsc_assertions (
  // clock and reset
  input wire logic          CLK,
  input wire logic          RST,
  // slave cycle start
  input wire logic          PCI_WINDOW_SELECT_N,
  input wire logic          WINDOW_CHOICE,
  input wire lb_pkg::addr_t ADDR,
  input wire logic          XFER_START_N,
  input wire logic          BURST_N,
  input wire logic          DMA_ACK_N,
  input wire logic          WIN_READY,
  input wire logic          WIN_ERROR,
  // termination and channel outputs
  input wire logic          ACK_OUT_N,
  input wire logic          ACK_OE,
  input wire logic          ERR_OE,
  input wire logic          RETRY_OE,
  input wire logic          PCI_STROBE,
  input wire logic          IMAGE_SEL,
  // dma request
  input wire logic          SECOND_FAMILY,
  input wire logic          DMA_WANT,
  input wire logic          DMA_REQ_N,
  // arbitration
  input wire logic          BUS_BUSY_IN_N,
  input wire logic          GRANT_ACK_IN_N,
  input wire logic          BUS_BUSY_OE,
  // reset output
  input wire logic          SOFT_RESET_BIT,
  input wire logic          RESET_OUT_N,
  input wire logic          RESET_OE,
  // interrupts
  input wire logic          HOST_MODE,
  input wire logic          PCI_INT_IN_N,
  input wire logic          LOCAL_IRQ_OUT_N,
  input wire logic          LOCAL_IRQ_OE,
  input wire logic          LOCAL_IRQ_IN_N,
  input wire logic          PCI_INT_OUT_N,
  input wire logic          PCI_INT_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  import lb_pkg::*;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // starts seen from an idle sequencer
  wire idle_w  = !ACK_OE && !ERR_OE && !RETRY_OE;
  wire start_w = !XFER_START_N && idle_w && !PCI_WINDOW_SELECT_N && WIN_READY;
  wire burst_w = start_w && DMA_ACK_N && !BURST_N && !WIN_ERROR;
  wire dual_w  = start_w && !DMA_ACK_N;

  burst_unaligned_a: assert property (
    burst_w && ADDR[3:0] != 4'h0 |-> ##1 ACK_OUT_N [*3] ##1 !ACK_OUT_N)
    else $error("unaligned burst timing");
  burst_aligned_a: assert property (
    burst_w && ADDR[3:0] == 4'h0 |-> ##1 ACK_OUT_N [*2] ##1 !ACK_OUT_N)
    else $error("aligned burst timing");
  dma_addr_free_a: assert property (
    dual_w |-> ##1 ACK_OUT_N [*2] ##1 !ACK_OUT_N)
    else $error("dual dma timing");
  dma_no_abort_a: assert property (
    ERR_OE || RETRY_OE |-> DMA_ACK_N)
    else $error("abort in dma");
  end_ignored_a: assert property (
    SECOND_FAMILY && $past(SECOND_FAMILY) && DMA_WANT && !$past(DMA_REQ_N) |-> !DMA_REQ_N)
    else $error("end not ignored");
  image_pick_a: assert property (
    PCI_STROBE |-> IMAGE_SEL == $past(WINDOW_CHOICE))
    else $error("wrong slave image");
  grant_after_a: assert property (
    $rose(BUS_BUSY_OE) |-> $past(BUS_BUSY_IN_N) && $past(GRANT_ACK_IN_N))
    else $error("bus taken while busy");
  rst_drive_a: assert property (
    disable iff (1'h0) RST |-> !RESET_OUT_N && RESET_OE)
    else $error("reset output idle");
  soft_follow_a: assert property (
    !$past(RST) |-> RESET_OUT_N == !$past(SOFT_RESET_BIT) && RESET_OE == $past(SOFT_RESET_BIT))
    else $error("reset output lags soft bit");
  host_irq_a: assert property (
    (HOST_MODE && !PCI_INT_IN_N) [*6] |-> !LOCAL_IRQ_OUT_N && LOCAL_IRQ_OE)
    else $error("local irq not raised");
  card_irq_a: assert property (
    (!HOST_MODE && !LOCAL_IRQ_IN_N) [*6] |-> !PCI_INT_OUT_N && PCI_INT_OE)
    else $error("pci int not raised");

  // main scenarios reached
  burst_c: cover property (burst_w);
  dual_c: cover property (dual_w);
  grant_c: cover property ($rose(BUS_BUSY_OE));
endmodule // lbsc_assertions

bind local_bus_side_control lbsc_assertions lbsc_assertions_inst (.*);

`default_nettype wire

// [dv/local_bus_side_control_test.sv]
// self-checking bench for the local bus side control
// assumes other_master as the far bus master and the bound checker
`default_nettype none

module local_bus_side_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lb_pkg::*;

  logic  CLK, RST, REG_SPACE_SELECT_N, PCI_WINDOW_SELECT_N, WINDOW_CHOICE, XFER_START_N;
  logic  BURST_N, READ, ACK_IN_N, DMA_ACK_N, XFER_END_N, SECOND_FAMILY, DMA_WANT;
  logic  WIN_READY, WIN_ERROR, SOFT_RESET_BIT, QM_REQ, QM_DONE, HOST_MODE;
  logic  pci_int_drv_n, local_irq_drv_n;
  addr_t ADDR;
  wire logic ACK_OUT_N, ACK_OE, ERR_OUT_N, ERR_OE, RETRY_OUT_N, RETRY_OE, DMA_REQ_N;
  wire logic REG_STROBE, PCI_STROBE, IMAGE_SEL, ACC_WRITE, ACC_BURST, DMA_BEAT;
  wire logic QM_GRANTED, BUS_GRANT_N, BUS_REQ_N, BUS_BUSY_IN_N, BUS_BUSY_OUT_N;
  wire logic BUS_BUSY_OE, GRANT_ACK_IN_N, GRANT_ACK_OUT_N, GRANT_ACK_OE, RESET_OUT_N;
  wire logic RESET_OE, PCI_INT_IN_N, PCI_INT_OUT_N, PCI_INT_OE, LOCAL_IRQ_IN_N;
  wire logic LOCAL_IRQ_OUT_N, LOCAL_IRQ_OE, other_busy, other_free;
  int    bad_count, cmp_count, cyc, n;
  logic  ab;

  // wired levels: pull-ups unless some party drives low
  assign BUS_BUSY_IN_N  = !((BUS_BUSY_OE && !BUS_BUSY_OUT_N) || other_busy);
  assign GRANT_ACK_IN_N = !((GRANT_ACK_OE && !GRANT_ACK_OUT_N) || other_busy);
  assign PCI_INT_IN_N   = (PCI_INT_OE && !PCI_INT_OUT_N) ? 1'h0 : pci_int_drv_n;
  assign LOCAL_IRQ_IN_N = (LOCAL_IRQ_OE && !LOCAL_IRQ_OUT_N) ? 1'h0 : local_irq_drv_n;

  local_bus_side_control local_bus_side_control_inst (.*);
  other_master other_master_inst (.clk(CLK), .rst(RST), .bus_req_n(BUS_REQ_N),
    .hold(4'h5), .grant_n(BUS_GRANT_N), .busy_low(other_busy), .released(other_free));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge CLK);
  endtask

  // one slave cycle; n is the cycle index of the first termination
  task automatic bus_cycle(input logic rs_n, ws_n, dk_n, bu_n, rd, input logic [3:0] a,
                           input int ready_at);
    REG_SPACE_SELECT_N  = rs_n;
    PCI_WINDOW_SELECT_N = ws_n;
    DMA_ACK_N           = dk_n;
    BURST_N             = bu_n;
    READ                = rd;
    ADDR                = {28'h000_0000, a};
    XFER_START_N        = 1'h0;
    tick(1);
    XFER_START_N = 1'h1;
    n  = 1;
    ab = ERR_OE | RETRY_OE;
    while (ACK_OUT_N && ERR_OUT_N && RETRY_OUT_N && n < 30 && !DMA_BEAT) begin
      tick(1);
      n++;
      ab = ab | ERR_OE | RETRY_OE;
      if (n == ready_at) WIN_READY = 1'h1;
    end
    repeat (8) if (ACK_OE || ERR_OE || RETRY_OE) tick(1);
    REG_SPACE_SELECT_N  = 1'h1;
    PCI_WINDOW_SELECT_N = 1'h1;
    DMA_ACK_N           = 1'h1;
    tick(1);
  endtask

  task automatic s_reset();
    tick(10);
    check({RESET_OUT_N, RESET_OE}, 2'h1);
    RST = 1'h0;
    tick(2);
    check(RESET_OUT_N, 1'h1);
    SOFT_RESET_BIT = 1'h1;
    tick(2);
    check(RESET_OUT_N, 1'h0);
    SOFT_RESET_BIT = 1'h0;
    tick(2);
    check(RESET_OUT_N, 1'h1);
  endtask

  task automatic s_selects();
    for (int c = 0; c < 2; c++) begin
      WINDOW_CHOICE = c[0];
      bus_cycle(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'h0, 0);
      check(n, 4);
      check(IMAGE_SEL, c[0]);
    end
    bus_cycle(1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 0);
    check(n, 4);
    bus_cycle(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0, 0);
    check(n, 7);
  endtask

  task automatic s_burst();
    for (int i = 0; i < 4; i++) begin
      bus_cycle(1'h1, 1'h0, 1'h1, 1'h0, i[0], i[1] ? 4'h4 : 4'h0, 0);
      check({ACC_WRITE, n[3:0]}, {!i[0], i[1] ? 4'h4 : 4'h3});
    end
  endtask

  task automatic s_dma();
    bus_cycle(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 4'h8, 0);
    check(n, 3);
    WIN_ERROR = 1'h1;
    bus_cycle(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h2, 0);
    check({ab, ACK_OUT_N}, 2'h1);
    WIN_ERROR = 1'h0;
    WIN_READY = 1'h0;
    bus_cycle(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0, 6);
    check(ab, 1'h0);
    check(n > 6 && n < 30, 1'h1);
    WIN_READY = 1'h0;
    bus_cycle(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'h0, 0);
    check({ab, n[3:0]}, 5'h13);
    ACK_IN_N = 1'h0;
    bus_cycle(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 0);
    check(n, 2);
    WIN_READY = 1'h1;
  endtask

  task automatic s_dma_req();
    DMA_WANT      = 1'h1;
    DMA_ACK_N     = 1'h0;
    SECOND_FAMILY = 1'h1;
    XFER_END_N    = 1'h0;
    tick(3);
    check(DMA_REQ_N, 1'h0);
    SECOND_FAMILY = 1'h0;
    tick(2);
    check(DMA_REQ_N, 1'h1);
    XFER_END_N = 1'h1;
    DMA_ACK_N  = 1'h1;
    DMA_WANT   = 1'h0;
    tick(2);
    DMA_WANT = 1'h1;
    tick(1);
    check(DMA_REQ_N, 1'h0);
    DMA_WANT = 1'h0;
  endtask

  task automatic s_arb();
    QM_REQ = 1'h1;
    for (int k = 0; k < 40 && QM_GRANTED !== 1'h1; k++) tick(1);
    check({QM_GRANTED, other_free}, 2'h3);
    check({BUS_BUSY_IN_N, GRANT_ACK_IN_N}, 2'h0);
    QM_DONE = 1'h1;
    tick(1);
    QM_DONE = 1'h0;
    QM_REQ  = 1'h0;
    tick(2);
    check({QM_GRANTED, BUS_BUSY_OE}, 2'h0);
  endtask

  task automatic s_irq();
    HOST_MODE     = 1'h1;
    pci_int_drv_n = 1'h0;
    tick(8);
    check({LOCAL_IRQ_OUT_N, LOCAL_IRQ_OE}, 2'h1);
    pci_int_drv_n = 1'h1;
    tick(8);
    check(LOCAL_IRQ_OE, 1'h0);
    HOST_MODE       = 1'h0;
    local_irq_drv_n = 1'h0;
    tick(8);
    check({PCI_INT_OUT_N, PCI_INT_OE}, 2'h1);
    local_irq_drv_n = 1'h1;
    tick(8);
    check(PCI_INT_OE, 1'h0);
  endtask

  // clock
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end

  // hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // main sequence; selects idle, window ready, reset held 20 cycles
  initial begin
    {RST, REG_SPACE_SELECT_N, PCI_WINDOW_SELECT_N, XFER_START_N, BURST_N} = 5'h1f;
    {READ, ACK_IN_N, DMA_ACK_N, XFER_END_N, WIN_READY} = 5'h1f;
    {WINDOW_CHOICE, SECOND_FAMILY, DMA_WANT, WIN_ERROR, SOFT_RESET_BIT} = 5'h00;
    {QM_REQ, QM_DONE, HOST_MODE, pci_int_drv_n, local_irq_drv_n} = 5'h03;
    ADDR = 32'h0000_0000;
    tick(10);
    s_reset();
    s_selects();
    s_burst();
    s_dma();
    s_dma_req();
    s_arb();
    s_irq();
    report_and_stop();
  end
endmodule // local_bus_side_control_test

`default_nettype wire

// [dv/other_master.sv]
// model of the other local bus master that holds the bus at reset
// assumes the bench resolves busy and grant-ack wires with pull-ups
`default_nettype none

module other_master (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // arbitration
  input  wire logic       bus_req_n,
  input  wire logic [3:0] hold,
  output logic            grant_n,
  output logic            busy_low,
  output logic            released
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt_q;

  // once asked, finish own cycle for hold + 1 clocks, then let the lines float high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q    <= 4'h0;
      released <= 1'h0;
    end else if ((!bus_req_n || cnt_q != 4'h0) && !released) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == hold) begin
        released <= 1'h1;
      end
    end
  end

  // grant follows the request; busy and grant-ack low while owning
  assign grant_n  = bus_req_n;
  assign busy_low = !released;
endmodule // other_master

`default_nettype wire

// [hw/arb_if.sv]
// request and grant between the slave top and the bus ownership module
// assumes both ends on the same local bus clock
`default_nettype none

interface arb_if;
  logic req;
  logic done;
  logic granted;

  modport owner (input req, input done, output granted);
  modport user  (output req, output done, input granted);
endinterface : arb_if

`default_nettype wire

// [hw/bus_owner.sv]
// local bus ownership: request, wait for grant and release, then hold
// assumes arbitration pins synchronous to clk
`default_nettype none

module bus_owner (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // request side
  arb_if.owner      arb,
  // arbitration pins
  input  wire logic bus_grant_n,
  input  wire logic bus_busy_in_n,
  input  wire logic grant_ack_in_n,
  output logic      bus_req_n,
  output logic      bus_busy_out_n,
  output logic      bus_busy_oe,
  output logic      grant_ack_out_n,
  output logic      grant_ack_oe
);
  import lb_pkg::*;

  arb_state_e state_q;
  arb_state_e state_d;
  logic       released;

  // the previous master has let go of both ownership lines
  assign released = bus_busy_in_n & grant_ack_in_n;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      AR_IDLE: if (arb.req) state_d = AR_REQ;
      AR_REQ:  if (!bus_grant_n) state_d = AR_WAIT;
      AR_WAIT: if (released) state_d = AR_OWN;
      AR_OWN:  if (arb.done) state_d = AR_IDLE;
      default: state_d = AR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_q <= AR_IDLE;
    else     state_q <= state_d;
  end

  // drive ownership only once held
  assign bus_req_n       = !(state_q == AR_REQ);
  assign arb.granted     = (state_q == AR_OWN);
  assign bus_busy_out_n  = !(state_q == AR_OWN);
  assign bus_busy_oe     = (state_q == AR_OWN);
  assign grant_ack_out_n = !(state_q == AR_OWN);
  assign grant_ack_oe    = (state_q == AR_OWN);

endmodule // bus_owner

`default_nettype wire

// [hw/lb_pkg.sv]
// types shared by the local bus side control modules
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package lb_pkg;

  typedef logic [31:0] addr_t;

  // slave cycle sequencer, gray along idle -> wait -> term
  typedef enum logic [1:0] {
    SL_IDLE = 2'h0,
    SL_WAIT = 2'h1,
    SL_TERM = 2'h3
  } slave_state_e;

  // bus ownership sequencer, gray along the usual path
  typedef enum logic [1:0] {
    AR_IDLE = 2'h0,
    AR_REQ  = 2'h1,
    AR_WAIT = 2'h3,
    AR_OWN  = 2'h2
  } arb_state_e;

  // kind of the slave cycle in progress
  typedef enum logic [2:0] {
    ACC_NONE = 3'h0,
    ACC_REG  = 3'h1,
    ACC_PCI  = 3'h2,
    ACC_DMA1 = 3'h3,
    ACC_DMA2 = 3'h4
  } acc_e;

  // how the cycle will be terminated
  typedef enum logic [1:0] {
    TT_ACK   = 2'h0,
    TT_RETRY = 2'h1,
    TT_ERR   = 2'h2
  } term_e;

endpackage : lb_pkg

`default_nettype wire

// [hw/lb_regs.svh]
// timing and field constants for the local bus side control
// assumes inclusion by bare name from the design files
`ifndef LB_REGS_SVH
`define LB_REGS_SVH

// wait state counter width and wait figures per access kind
`define LB_WAIT_W        3
`define LB_W_REG_RD      3'h2
`define LB_W_REG_WR      3'h5
`define LB_W_RETRY       3'h1
`define LB_W_BURST_WR    3'h1
`define LB_W_POST_WR     3'h1
`define LB_W_READ        3'h2
`define LB_W_BURST_RD    3'h1
`define LB_W_UNALIGNED   3'h1
`define LB_W_DMA         3'h1
`define LB_W_NONE        3'h0

// burst geometry: address bits below a 16-byte line, beats after the first
`define LB_LINE_MSB      3
`define LB_LINE_ZERO     4'h0
`define LB_BEAT_W        2
`define LB_BEATS_LEFT    2'h3
`define LB_BEAT_NONE     2'h0

// reset values of the pin synchronisers (idle high)
`define LB_SYNC_W        2
`define LB_SYNC_IDLE     2'h3

`endif

// [hw/local_bus_side_control.sv]
// local bus side control of a processor-bus to PCI bridge
// assumes local bus pins synchronous to CLK; RST is the PCI reset, high
//
// What this block does
// - With the second processor family the transfer-end input is ignored entirely.
// - During handshake DMA the address lines are never decoded or used.
// - Dual-address handshake DMA cycles never end in retry or bus error.
// - Bursts outside handshake DMA that start off a 16-byte boundary get one extra wait state.
// - Bus ownership is taken only after the other master releases busy and grant-ack.
// - The reset output is asserted while the PCI reset is active.
// - Setting the software reset bit asserts the reset output.
// - With the window selected, image 0 is used when the choice pin is low, else image 1.
// - As host bridge, PCI INT# in drives the local interrupt output.
// - As adapter card, the local interrupt pin in drives PCI INT# out.
`default_nettype none
`include "lb_regs.svh"

module local_bus_side_control (
  // clock and reset
  input  wire logic         CLK,
  input  wire logic         RST,
  // selects and address phase
  input  wire logic         REG_SPACE_SELECT_N,
  input  wire logic         PCI_WINDOW_SELECT_N,
  input  wire logic         WINDOW_CHOICE,
  input  wire lb_pkg::addr_t ADDR,
  input  wire logic         XFER_START_N,
  input  wire logic         BURST_N,
  input  wire logic         READ,
  // cycle termination pins
  input  wire logic         ACK_IN_N,
  output logic              ACK_OUT_N,
  output logic              ACK_OE,
  output logic              ERR_OUT_N,
  output logic              ERR_OE,
  output logic              RETRY_OUT_N,
  output logic              RETRY_OE,
  // handshake dma
  input  wire logic         DMA_ACK_N,
  input  wire logic         XFER_END_N,
  input  wire logic         SECOND_FAMILY,
  input  wire logic         DMA_WANT,
  output logic              DMA_REQ_N,
  // internal channels
  input  wire logic         WIN_READY,
  input  wire logic         WIN_ERROR,
  input  wire logic         SOFT_RESET_BIT,
  output logic              REG_STROBE,
  output logic              PCI_STROBE,
  output logic              IMAGE_SEL,
  output logic              ACC_WRITE,
  output logic              ACC_BURST,
  output logic              DMA_BEAT,
  // local bus master request
  input  wire logic         QM_REQ,
  input  wire logic         QM_DONE,
  output logic              QM_GRANTED,
  // arbitration pins
  input  wire logic         BUS_GRANT_N,
  output logic              BUS_REQ_N,
  input  wire logic         BUS_BUSY_IN_N,
  output logic              BUS_BUSY_OUT_N,
  output logic              BUS_BUSY_OE,
  input  wire logic         GRANT_ACK_IN_N,
  output logic              GRANT_ACK_OUT_N,
  output logic              GRANT_ACK_OE,
  // reset output
  output logic              RESET_OUT_N,
  output logic              RESET_OE,
  // interrupts
  input  wire logic         HOST_MODE,
  input  wire logic         PCI_INT_IN_N,
  output logic              PCI_INT_OUT_N,
  output logic              PCI_INT_OE,
  input  wire logic         LOCAL_IRQ_IN_N,
  output logic              LOCAL_IRQ_OUT_N,
  output logic              LOCAL_IRQ_OE
);
  import lb_pkg::*;

  // ---- slave cycle state
  slave_state_e             state_q;
  slave_state_e             state_d;
  acc_e                     kind_q;
  acc_e                     kind_d;
  term_e                    term_q;
  term_e                    term_d;
  logic [`LB_WAIT_W-1:0]    wait_q;
  logic [`LB_WAIT_W-1:0]    wait_d;
  logic [`LB_BEAT_W-1:0]    beat_q;
  logic [`LB_BEAT_W-1:0]    beat_d;
  logic                     burst_q;
  logic                     write_q;
  logic                     image_q;

  // ---- decode wires
  logic                     sel_reg;
  logic                     sel_win;
  logic                     dma_ack;
  logic                     start;
  logic                     unaligned;
  logic [`LB_WAIT_W-1:0]    base_waits;
  logic [`LB_WAIT_W-1:0]    extra_waits;
  acc_e                     start_kind;
  term_e                    start_term;
  logic                     wait_done;
  logic                     dual_hold;
  logic                     last_beat;
  logic                     drives_term;

  // ---- strobes and dma
  logic                     reg_stb_q;
  logic                     pci_stb_q;
  logic                     dma_beat_q;
  logic                     dma_beat_d;
  logic                     end_seen_q;
  logic                     end_hit;

  // ---- reset and interrupt
  logic                     reset_q;
  logic [`LB_SYNC_W-1:0]    irq_sync;
  logic                     pci_int_act;
  logic                     loc_irq_act;
  logic                     loc_irq_q;
  logic                     pci_int_q;

  arb_if                    arb ();

  // selects: two separate chip selects, never the address, drive the choice
  assign dma_ack = !DMA_ACK_N;
  assign sel_reg = !REG_SPACE_SELECT_N && !dma_ack;
  assign sel_win = !PCI_WINDOW_SELECT_N;
  assign start   = !XFER_START_N && (state_q == SL_IDLE)
                   && (sel_reg || sel_win || dma_ack);

  // kind of cycle; single-address dma relies on the window select being off
  assign start_kind = dma_ack ? (sel_win ? ACC_DMA2 : ACC_DMA1)
                    : sel_reg ? ACC_REG : ACC_PCI;

  // alignment check uses the address only outside dma cycles
  assign unaligned = !dma_ack && !BURST_N
                     && (ADDR[`LB_LINE_MSB:0] != `LB_LINE_ZERO);
  assign extra_waits = unaligned ? `LB_W_UNALIGNED : `LB_W_NONE;

  // wait states per kind of access
  always_comb begin
    base_waits = `LB_W_NONE;
    case (start_kind)
      ACC_REG:  base_waits = READ ? `LB_W_REG_RD : `LB_W_REG_WR;
      ACC_PCI: begin
        if (!WIN_READY)   base_waits = `LB_W_RETRY;
        else if (READ)    base_waits = BURST_N ? `LB_W_READ : `LB_W_BURST_RD;
        else              base_waits = BURST_N ? `LB_W_POST_WR : `LB_W_BURST_WR;
      end
      ACC_DMA2: base_waits = `LB_W_DMA;
      default:  base_waits = `LB_W_NONE;
    endcase
  end

  // termination chosen at start; dual-address dma is never refused
  always_comb begin
    start_term = TT_ACK;
    if (start_kind == ACC_PCI && !WIN_READY) begin
      start_term = TT_RETRY;
    end
  end

  // sequencer conditions
  assign wait_done = (wait_q == `LB_W_NONE);
  assign dual_hold = (kind_q == ACC_DMA2) && !WIN_READY;
  assign last_beat = !burst_q || (beat_q == `LB_BEAT_NONE)
                     || (term_q != TT_ACK);

  // slave sequencer next state
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    term_d  = term_q;
    wait_d  = wait_q;
    beat_d  = beat_q;
    case (state_q)
      SL_IDLE: begin
        if (start) begin
          state_d = SL_WAIT;
          kind_d  = start_kind;
          term_d  = start_term;
          wait_d  = `LB_WAIT_W'(base_waits + extra_waits);
          beat_d  = `LB_BEATS_LEFT;
        end
      end
      SL_WAIT: begin
        if (kind_q == ACC_DMA1) begin
          // the memory acknowledges; this block only watches
          if (!ACK_IN_N || !dma_ack) begin
            state_d = SL_IDLE;
            kind_d  = ACC_NONE;
          end
        end else if (!wait_done) begin
          wait_d = wait_q - `LB_WAIT_W'(1);
        end else if (!dual_hold) begin
          state_d = SL_TERM;
          if (WIN_ERROR && kind_q == ACC_PCI && term_q == TT_ACK) begin
            term_d = TT_ERR; // dual dma never lands here
          end
        end
      end
      SL_TERM: begin
        if (last_beat) begin
          state_d = SL_IDLE;
          kind_d  = ACC_NONE;
        end else begin
          beat_d = beat_q - `LB_BEAT_W'(1);
        end
      end
      default: begin
        state_d = SL_IDLE;
        kind_d  = ACC_NONE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= SL_IDLE;
      kind_q  <= ACC_NONE;
      term_q  <= TT_ACK;
      wait_q  <= `LB_W_NONE;
      beat_q  <= `LB_BEAT_NONE;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      term_q  <= term_d;
      wait_q  <= wait_d;
      beat_q  <= beat_d;
    end
  end

  // attributes captured at the start of a cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      burst_q <= 1'b0;
      write_q <= 1'b0;
      image_q <= 1'b0;
    end else if (start) begin
      burst_q <= !BURST_N;
      write_q <= !READ;
      image_q <= sel_win && WINDOW_CHOICE;
    end
  end

  // termination pins, driven only for cycles this block ends
  assign drives_term = (state_q != SL_IDLE) && (kind_q != ACC_DMA1);
  assign ACK_OE      = drives_term;
  assign ERR_OE      = drives_term && (kind_q != ACC_DMA2);
  assign RETRY_OE    = drives_term && (kind_q != ACC_DMA2);
  assign ACK_OUT_N   = !((state_q == SL_TERM) && (term_q == TT_ACK));
  assign ERR_OUT_N   = !((state_q == SL_TERM) && (term_q == TT_ERR));
  assign RETRY_OUT_N = !((state_q == SL_TERM) && (term_q == TT_RETRY));

  // one-cycle strobes toward the register and PCI channels
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      reg_stb_q <= 1'b0;
      pci_stb_q <= 1'b0;
    end else begin
      reg_stb_q <= start && (start_kind == ACC_REG);
      pci_stb_q <= start && (start_term == TT_ACK)
                   && (start_kind == ACC_PCI || start_kind == ACC_DMA2);
    end
  end

  assign REG_STROBE = reg_stb_q;
  assign PCI_STROBE = pci_stb_q;
  assign IMAGE_SEL  = image_q;
  assign ACC_WRITE  = write_q;
  assign ACC_BURST  = burst_q;

  // dma beats: memory ack in single mode, own ack in dual mode
  assign dma_beat_d = ((state_q == SL_WAIT) && (kind_q == ACC_DMA1) && !ACK_IN_N)
                      || ((state_q == SL_TERM) && (kind_q == ACC_DMA2));

  // transfer end is honoured only outside the second family
  assign end_hit = dma_ack && !XFER_END_N && !SECOND_FAMILY;

  // dma request withdrawn after an end until the channel drops its want
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dma_beat_q <= 1'b0;
      end_seen_q <= 1'b0;
    end else begin
      dma_beat_q <= dma_beat_d;
      if (end_hit)        end_seen_q <= 1'b1;
      else if (!DMA_WANT) end_seen_q <= 1'b0;
    end
  end

  assign DMA_BEAT  = dma_beat_q;
  assign DMA_REQ_N = !(DMA_WANT && !end_seen_q);

  // bus ownership for the internal master
  assign arb.req    = QM_REQ;
  assign arb.done   = QM_DONE;
  assign QM_GRANTED = arb.granted;

  bus_owner u_owner (
    .clk             (CLK),
    .rst             (RST),
    .arb             (arb.owner),
    .bus_grant_n     (BUS_GRANT_N),
    .bus_busy_in_n   (BUS_BUSY_IN_N),
    .grant_ack_in_n  (GRANT_ACK_IN_N),
    .bus_req_n       (BUS_REQ_N),
    .bus_busy_out_n  (BUS_BUSY_OUT_N),
    .bus_busy_oe     (BUS_BUSY_OE),
    .grant_ack_out_n (GRANT_ACK_OUT_N),
    .grant_ack_oe    (GRANT_ACK_OE)
  );

  // reset output: held through PCI reset, then follows the soft bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) reset_q <= 1'b1;
    else     reset_q <= SOFT_RESET_BIT;
  end

  assign RESET_OUT_N = !reset_q;
  assign RESET_OE    = reset_q; // released line floats high

  // interrupt pins are asynchronous to the local clock
  sync3 #(.W(`LB_SYNC_W)) u_irq_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({PCI_INT_IN_N, LOCAL_IRQ_IN_N}),
    .q   (irq_sync)
  );

  assign pci_int_act = HOST_MODE && !irq_sync[1];
  assign loc_irq_act = !HOST_MODE && !irq_sync[0];

  // forward in the direction that the mode selects; no autovector drive
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      loc_irq_q <= 1'b0;
      pci_int_q <= 1'b0;
    end else begin
      loc_irq_q <= pci_int_act;
      pci_int_q <= loc_irq_act;
    end
  end

  assign LOCAL_IRQ_OUT_N = !loc_irq_q;
  assign LOCAL_IRQ_OE    = loc_irq_q;
  assign PCI_INT_OUT_N   = !pci_int_q;
  assign PCI_INT_OE      = pci_int_q;

endmodule // local_bus_side_control

`default_nettype wire

// [hw/sync3.sv]
// three-stage synchroniser; output moves once stages two and three agree
// assumes asynchronous inputs that idle high
`default_nettype none
`include "lb_regs.svh"

module sync3 #(
  parameter int W = `LB_SYNC_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // async level in, filtered level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;
  logic [W-1:0] agree;

  // bits move only where the last two stages match
  assign agree = ~(s2_q ^ s3_q);
  assign q_d   = (s2_q & agree) | (q & ~agree);

  // shift chain; the first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= W'(`LB_SYNC_IDLE);
      s2_q <= W'(`LB_SYNC_IDLE);
      s3_q <= W'(`LB_SYNC_IDLE);
      q    <= W'(`LB_SYNC_IDLE);
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= q_d;
    end
  end

endmodule // sync3

`default_nettype wire
